/* File: include/ssc_pkg.sv */
// constants of the spi status, interrupt-flag and crc block
// Behaviour
// R1 - FIFO error sets status bit 7; with transmit empty it means underflow.
// R2 - FIFO error flag with receive full reports receive overflow.
// R3 - FIFO error flag clears when software sets FIFO initialise.
// R4 - Status bit 2 reads 1 once a byte-mode receive interrupt triggered.
// R5 - Status bit 1 reads 1 once a byte-mode transmit interrupt triggered.
// R6 - Status bit 0 reads 1 once a block-mode interrupt triggered.
// R7 - Status register is read-only; writes change no flag.
// R8 - Writing 1 to clear bit 1 drops transmit interrupt; bit self-clears.
// R9 - Writing 1 to clear bit 0 drops block interrupt; bit self-clears.
// R10 - Software writes zeros to reserved bits of clear and crc control.
// R11 - Bits 15:14 pick polynomial: 16-bit ccitt, 7-bit, alternate 16-bit, reserved.
// R12 - CRC advances only while enable bit 13 is 1.
// R13 - Writing 1 to bit 12 loads all ones; bit reads back 0.
// R14 - Full duplex: bit 11 picks receive or transmit stream; ignored half duplex.
// R15 - Bit 10 reads 1 when crc value holds any one.
// R16 - Bit 9 reads 1 when crc value holds any zero.
// R17 - CRC value register is readable and writable for result or preset.
// R18 - Writing FIFO initialise resets the FIFOs and clears the error flag.
// R19 - Transmit empty bit 7 and receive full bit 6 show FIFO state.
// R20 - Enable bits 2,1,0 gate receive, transmit and block interrupts.
// R21 - Enabled crc steps once per serial bit, msb first through polynomial.
package ssc_pkg;
	localparam logic [15:0] ADDR_IRQ_ENABLE = 16'hc0cc;
	localparam logic [15:0] ADDR_STATUS_FLAGS = 16'hc0ce;
	localparam logic [15:0] ADDR_IRQ_CLEAR = 16'hc0d0;
	localparam logic [15:0] ADDR_CRC_CONTROL = 16'hc0d2;
	localparam logic [15:0] ADDR_CRC_VALUE = 16'hc0d4;
	localparam logic [15:0] ADDR_FIFO_CTRL = 16'hc0d6;

	localparam int BIT_FIFO_ERR = 7;
	localparam int BIT_RX_IRQ = 2;
	localparam int BIT_TX_IRQ = 1;
	localparam int BIT_BLK_IRQ = 0;
	localparam int BIT_FIFO_INIT = 14;
	localparam int BIT_TX_EMPTY = 7;
	localparam int BIT_RX_FULL = 6;
	localparam int POS_CRC_MODE = 14;
	localparam int BIT_CRC_ENABLE = 13;
	localparam int BIT_CRC_CLEAR = 12;
	localparam int BIT_CRC_RX_SEL = 11;
	localparam int BIT_ONE_IN_CRC = 10;
	localparam int BIT_ZERO_IN_CRC = 9;

	localparam logic [15:0] RESET_CRC_VALUE = 16'hffff;
	localparam logic [15:0] POLY_CCITT16 = 16'h1021;
	localparam logic [6:0] POLY_CRC7 = 7'h09;
	localparam logic [15:0] POLY_ALT16 = 16'h8005;
	localparam logic [15:0] POLY_RESERVED16 = 16'h0001;
	localparam logic [15:0] CRC7_MASK = 16'h007f;

	typedef enum logic [1:0] {
		SSC_CRC_CCITT16,
		SSC_CRC_CRC7,
		SSC_CRC_ALT16,
		SSC_CRC_RSVD16
	} ssc_crc_mode_t;
endpackage

/* File: src/ssc_status_crc.sv */
// spi status flags, interrupt gating and clear, fifo init and crc engine
`timescale 1ns/1ps
module ssc_status_crc (
	input wire logic clk, // 50 mhz system clock
	input wire logic resetn, // asynchronous reset, active low
	input wire logic [15:0] addr, // register address
	input wire logic [15:0] wdata, // write data
	input wire logic wr, // write strobe
	input wire logic rd, // read strobe
	output logic [15:0] rdata, // read data, cycle after rd
	input wire logic fifo_error_evt, // pulse: fifo under- or overflow
	input wire logic tx_empty, // transmit fifo empty level
	input wire logic rx_full, // receive fifo full level
	input wire logic byte_rx_evt, // pulse: byte-mode receive interrupt event
	input wire logic byte_rx_ack, // pulse: receive interrupt served
	input wire logic byte_tx_evt, // pulse: byte-mode transmit interrupt event
	input wire logic block_evt, // pulse: block-mode interrupt event
	input wire logic full_duplex, // level: full duplex operation
	input wire logic half_dup_rx, // level: half duplex currently receiving
	input wire logic bit_strobe, // pulse: one serial bit shifted
	input wire logic tx_bit, // transmit serial bit
	input wire logic rx_bit, // receive serial bit
	output logic fifo_reset, // pulse: initialise both fifos
	output logic byte_rx_irq, // gated receive interrupt
	output logic byte_tx_irq, // gated transmit interrupt
	output logic block_xfer_irq // gated block interrupt
);
	logic fifo_err;
	logic rx_flag;
	logic tx_flag;
	logic blk_flag;
	logic [2:0] irq_en;
	logic [1:0] crc_poly_select;
	logic crc_enable;
	logic crc_rx_sel;
	logic [15:0] crc;
	logic [15:0] next_crc;
	logic [15:0] next_rdata;
	logic crc_bit;
	logic one_in_crc;
	logic zero_in_crc;
	logic wr_clear;
	logic wr_crc_ctrl;
	logic wr_crc_value;
	logic wr_irq_en;
	logic fifo_init;

	function automatic logic hit(input logic [15:0] a, input logic [15:0] target);
		hit = (a == target);
	endfunction

	assign wr_clear = wr && hit(addr, ssc_pkg::ADDR_IRQ_CLEAR);
	assign wr_crc_ctrl = wr && hit(addr, ssc_pkg::ADDR_CRC_CONTROL);
	assign wr_crc_value = wr && hit(addr, ssc_pkg::ADDR_CRC_VALUE);
	assign wr_irq_en = wr && hit(addr, ssc_pkg::ADDR_IRQ_ENABLE);
	// fifo initialise is a command bit only; it never reads back
	assign fifo_init = wr && hit(addr, ssc_pkg::ADDR_FIFO_CTRL) && wdata[ssc_pkg::BIT_FIFO_INIT];

	// status flags; nothing decodes a write to the status address [R7]
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			fifo_err <= 1'b0;
		else
			fifo_err <= fifo_error_evt | (fifo_err & ~fifo_init); // [R1] [R2] [R3]
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			rx_flag <= 1'b0;
		else
			rx_flag <= byte_rx_evt | (rx_flag & ~byte_rx_ack); // [R4]
	end

	// an event in the clearing cycle wins, so no interrupt is lost
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			tx_flag <= 1'b0;
		else
			tx_flag <= byte_tx_evt | (tx_flag & ~(wr_clear & wdata[ssc_pkg::BIT_TX_IRQ])); // [R5] [R8]
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			blk_flag <= 1'b0;
		else
			blk_flag <= block_evt | (blk_flag & ~(wr_clear & wdata[ssc_pkg::BIT_BLK_IRQ])); // [R6] [R9]
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			fifo_reset <= 1'b0;
		else
			fifo_reset <= fifo_init; // [R18]
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			irq_en <= 3'h0;
		else if (wr_irq_en)
			irq_en <= wdata[2:0];
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			byte_rx_irq <= 1'b0;
			byte_tx_irq <= 1'b0;
			block_xfer_irq <= 1'b0;
		end
		else
		begin
			byte_rx_irq <= rx_flag & irq_en[ssc_pkg::BIT_RX_IRQ]; // [R20]
			byte_tx_irq <= tx_flag & irq_en[ssc_pkg::BIT_TX_IRQ]; // [R20]
			block_xfer_irq <= blk_flag & irq_en[ssc_pkg::BIT_BLK_IRQ]; // [R20]
		end
	end

	// crc control; reserved bits are simply not stored [R10]
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			crc_poly_select <= 2'h0;
			crc_enable <= 1'b0;
			crc_rx_sel <= 1'b0;
		end
		else if (wr_crc_ctrl)
		begin
			crc_poly_select <= wdata[ssc_pkg::POS_CRC_MODE +: 2]; // [R11]
			crc_enable <= wdata[ssc_pkg::BIT_CRC_ENABLE]; // [R12]
			crc_rx_sel <= wdata[ssc_pkg::BIT_CRC_RX_SEL]; // [R14]
		end
	end

	// in half duplex only one stream moves, so the select bit is moot
	always_comb
	begin
		if (full_duplex)
			crc_bit = crc_rx_sel ? rx_bit : tx_bit; // [R14]
		else
			crc_bit = half_dup_rx ? rx_bit : tx_bit;
	end

	always_comb
	begin
		next_crc = crc;
		if (wr_crc_ctrl && wdata[ssc_pkg::BIT_CRC_CLEAR])
			next_crc = ssc_pkg::RESET_CRC_VALUE; // [R13]
		else if (wr_crc_value)
			next_crc = wdata; // [R17]
		else if (crc_enable && bit_strobe) // [R12]
		begin
			case (ssc_pkg::ssc_crc_mode_t'(crc_poly_select)) // [R11] [R21]
				ssc_pkg::SSC_CRC_CCITT16:
					next_crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ crc_bit) ? ssc_pkg::POLY_CCITT16 : 16'h0000);
				ssc_pkg::SSC_CRC_CRC7:
					next_crc = {9'h000, {crc[5:0], 1'b0} ^ ((crc[6] ^ crc_bit) ? ssc_pkg::POLY_CRC7 : 7'h00)};
				ssc_pkg::SSC_CRC_ALT16:
					next_crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ crc_bit) ? ssc_pkg::POLY_ALT16 : 16'h0000);
				default:
					next_crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ crc_bit) ? ssc_pkg::POLY_RESERVED16 : 16'h0000);
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			crc <= ssc_pkg::RESET_CRC_VALUE;
		else
			crc <= next_crc;
	end

	// flags look only at the seven live bits in crc7 mode
	always_comb
	begin
		if (crc_poly_select == 2'h1)
		begin
			one_in_crc = |(crc & ssc_pkg::CRC7_MASK); // [R15]
			zero_in_crc = (crc & ssc_pkg::CRC7_MASK) != ssc_pkg::CRC7_MASK; // [R16]
		end
		else
		begin
			one_in_crc = |crc; // [R15]
			zero_in_crc = ~&crc; // [R16]
		end
	end

	always_comb
	begin
		next_rdata = 16'h0000;
		if (hit(addr, ssc_pkg::ADDR_STATUS_FLAGS))
		begin
			next_rdata[ssc_pkg::BIT_FIFO_ERR] = fifo_err; // [R1]
			next_rdata[ssc_pkg::BIT_RX_IRQ] = rx_flag; // [R4]
			next_rdata[ssc_pkg::BIT_TX_IRQ] = tx_flag; // [R5]
			next_rdata[ssc_pkg::BIT_BLK_IRQ] = blk_flag; // [R6]
		end
		else if (hit(addr, ssc_pkg::ADDR_IRQ_ENABLE))
			next_rdata[2:0] = irq_en;
		else if (hit(addr, ssc_pkg::ADDR_CRC_CONTROL))
		begin
			next_rdata[ssc_pkg::POS_CRC_MODE +: 2] = crc_poly_select;
			next_rdata[ssc_pkg::BIT_CRC_ENABLE] = crc_enable;
			next_rdata[ssc_pkg::BIT_CRC_RX_SEL] = crc_rx_sel;
			next_rdata[ssc_pkg::BIT_ONE_IN_CRC] = one_in_crc; // [R15]
			next_rdata[ssc_pkg::BIT_ZERO_IN_CRC] = zero_in_crc; // [R16]
		end
		else if (hit(addr, ssc_pkg::ADDR_CRC_VALUE))
			next_rdata = crc; // [R17]
		else if (hit(addr, ssc_pkg::ADDR_FIFO_CTRL))
		begin
			next_rdata[ssc_pkg::BIT_TX_EMPTY] = tx_empty; // [R19]
			next_rdata[ssc_pkg::BIT_RX_FULL] = rx_full; // [R19]
		end
	end

	// read data stands one cycle only; zero otherwise
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			rdata <= 16'h0000;
		else if (rd)
			rdata <= next_rdata;
		else
			rdata <= 16'h0000;
	end
endmodule

/* File: sim/ssc_status_crc_properties.sv */
// assertions on flag reads, clears and crc registers
`timescale 1ns/1ps
module ssc_props (
	input wire logic clk, // clock
	input wire logic resetn, // reset
	input wire logic [15:0] addr, // address
	input wire logic [15:0] wdata, // data
	input wire logic wr, // write
	input wire logic rd, // read
	input wire logic [15:0] rdata, // read data
	input wire logic byte_tx_evt, // tx event
	input wire logic block_evt, // block event
	input wire logic fifo_reset, // fifo init
	input wire logic byte_tx_irq, // tx irq
	input wire logic block_xfer_irq // block irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	wire logic w_clr = wr && addr == 16'hc0d0;
	wire logic w_ctl = wr && addr == 16'hc0d2;
	sequence st_rd;
		rd && addr == 16'hc0ce;
	endsequence
	sequence ctl_rd;
		rd && addr == 16'hc0d2;
	endsequence
	a_fifo_init_pulse: assert property (wr && addr == 16'hc0d6 && wdata[14] |=> fifo_reset)
		else $error("no fifo reset");
	a_tx_irq_clear: assert property (w_clr && wdata[1] && !byte_tx_evt |=> ##1 !byte_tx_irq)
		else $error("tx irq kept");
	a_blk_irq_clear: assert property (w_clr && wdata[0] && !block_evt |=> ##1 !block_xfer_irq)
		else $error("block irq kept");
	a_tx_flag_read: assert property (byte_tx_evt ##1 st_rd |=> rdata[1])
		else $error("tx flag missing");
	a_crc_clear_ones: assert property (w_ctl && wdata[12] ##1 rd && addr == 16'hc0d4 |=> rdata == 16'hffff)
		else $error("crc not all ones");
	a_ctl_readback: assert property (w_ctl ##1 ctl_rd |=>
		rdata[15:11] == {$past(wdata[15:13], 2), 1'b0, $past(wdata[11], 2)}) else $error("bad control");
	a_ones_flags: assert property (w_ctl && wdata[12] ##1 ctl_rd |=> rdata[10:9] == 2'b10)
		else $error("bad crc flags");
	a_crc_preset: assert property (wr && addr == 16'hc0d4 ##1 rd && addr == 16'hc0d4 |=>
		rdata == $past(wdata, 2)) else $error("preset lost");
endmodule
bind ssc_status_crc ssc_props u_props (.clk, .resetn, .addr, .wdata, .wr, .rd, .rdata,
	.byte_tx_evt, .block_evt, .fifo_reset, .byte_tx_irq, .block_xfer_irq);

/* File: sim/ssc_bit_src.sv */
// serial bit source standing in for the far end of the link
`timescale 1ns/1ps
module ssc_bit_src (
	input wire logic clk, // clock
	input wire logic resetn, // reset
	input wire logic start, // load pat
	input wire logic slow, // bit every other cycle
	input wire logic [15:0] pat, // bits, msb first
	output logic bit_strobe, // bit valid
	output logic tx_bit, // tx stream
	output logic rx_bit, // rx stream
	output logic busy // bits left
);
	logic [15:0] sh;
	logic [4:0] cnt;
	logic gap;
	assign busy = cnt != 5'h00;
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			{sh, cnt, gap, bit_strobe, tx_bit, rx_bit} <= '0;
		else if (start)
		begin
			sh <= pat;
			cnt <= 5'h10;
		end
		else if (busy && (gap || !slow))
		begin
			bit_strobe <= 1'b1;
			{tx_bit, rx_bit} <= {sh[15], sh[15] ^ cnt[0]};
			sh <= sh << 1;
			cnt <= cnt - 5'h01;
			gap <= 1'b0;
		end
		else
		begin
			// lines hold the old bit only in a start cycle, so a late sample shows up
			bit_strobe <= 1'b0;
			{tx_bit, rx_bit} <= ~{tx_bit, rx_bit};
			gap <= 1'b1;
		end
	end
endmodule

/* File: sim/testbench.sv */
// self-checking bench for the spi status and crc block
`timescale 1ns/1ps
module testbench;
	logic clk, resetn, wr, rd, fifo_error_evt, tx_empty, rx_full, byte_rx_evt, byte_rx_ack;
	logic byte_tx_evt, block_evt, full_duplex, half_dup_rx, bit_strobe, tx_bit, rx_bit;
	logic fifo_reset, byte_rx_irq, byte_tx_irq, block_xfer_irq, start, slow, busy;
	logic [15:0] addr, wdata, rdata, pat;
	int error_cnt = 0, n_checks = 0, cyc = 0;
	ssc_status_crc dut (.clk, .resetn, .addr, .wdata, .wr, .rd, .rdata, .fifo_error_evt,
		.tx_empty, .rx_full, .byte_rx_evt, .byte_rx_ack, .byte_tx_evt, .block_evt,
		.full_duplex, .half_dup_rx, .bit_strobe, .tx_bit, .rx_bit, .fifo_reset,
		.byte_rx_irq, .byte_tx_irq, .block_xfer_irq);
	ssc_bit_src u_src (.clk, .resetn, .start, .slow, .pat, .bit_strobe, .tx_bit, .rx_bit, .busy);
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// tasks start just after a rising edge; a pending strobe drop costs one cycle
	task automatic wr16(input logic [15:0] a, input logic [15:0] d);
		if (wr)
			@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd16(input logic [15:0] a, input logic [15:0] exp);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(rdata, exp);
		@(posedge clk);
	endtask
	task automatic irq_chk(input logic [2:0] e);
		repeat (2) @(negedge clk);
		chk({13'h0000, byte_rx_irq, byte_tx_irq, block_xfer_irq}, {13'h0000, e});
		@(posedge clk);
	endtask
	task automatic crc_run(input logic [1:0] m, input logic en, input logic rs, input logic [15:0] p);
		logic [15:0] c, poly, mk;
		logic fb;
		c = 16'hffff;
		mk = m == 2'b01 ? 16'h007f : 16'hffff;
		poly = m == 2'b00 ? 16'h1021 : m == 2'b01 ? 16'h0009 : m == 2'b10 ? 16'h8005 : 16'h0001;
		for (int i = 0; i < 16 && en; i++)
		begin
			fb = (m == 2'b01 ? c[6] : c[15]) ^ p[15 - i] ^ (rs & full_duplex & i[0]);
			c = ((c << 1) ^ (fb ? poly : 16'h0000)) & mk;
		end
		wr16(16'hc0d2, {m, en, 1'b1, rs, 11'h000});
		rd16(16'hc0d4, 16'hffff);
		start <= 1'b1;
		slow <= m[0];
		pat <= p;
		@(posedge clk);
		start <= 1'b0;
		@(negedge clk);
		for (int i = 0; i < 40 && busy; i++)
			@(negedge clk);
		repeat (2) @(posedge clk);
		rd16(16'hc0d4, c);
		rd16(16'hc0d2, {m, en, 1'b0, rs, |(c & mk), ~&(c | ~mk), 9'h000});
	endtask
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			error_cnt++;
			finish_test();
		end
	end
	initial
	begin
		{resetn, addr, wdata, wr, rd, fifo_error_evt, tx_empty, rx_full, byte_rx_evt} = '0;
		{byte_rx_ack, byte_tx_evt, block_evt, full_duplex, half_dup_rx, start, slow, pat} = '0;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		rd16(16'hc0ce, 16'h0000);
		rd16(16'hc0e0, 16'h0000);
		{fifo_error_evt, byte_rx_evt, byte_tx_evt, block_evt, tx_empty, rx_full} <= 6'h3f;
		@(posedge clk);
		{fifo_error_evt, byte_rx_evt, byte_tx_evt, block_evt} <= 4'h0;
		rd16(16'hc0ce, 16'h0087);
		rd16(16'hc0d6, 16'h00c0);
		wr16(16'hc0ce, 16'h0000);
		rd16(16'hc0ce, 16'h0087);
		wr16(16'hc0cc, 16'h0007);
		irq_chk(3'h7);
		wr16(16'hc0d0, 16'h0000);
		wr16(16'hc0d0, 16'h0002);
		irq_chk(3'h5);
		wr16(16'hc0d0, 16'h0001);
		irq_chk(3'h4);
		wr16(16'hc0cc, 16'h0000);
		irq_chk(3'h0);
		wr16(16'hc0d6, 16'h4000);
		rd16(16'hc0ce, 16'h0004);
		$display("flag test done");
		crc_run(2'b00, 1'b1, 1'b1, 16'ha53c);
		crc_run(2'b01, 1'b1, 1'b0, 16'h5a0f);
		crc_run(2'b10, 1'b1, 1'b0, 16'h1234);
		crc_run(2'b11, 1'b1, 1'b0, 16'hf00d);
		crc_run(2'b00, 1'b0, 1'b0, 16'hbeef);
		full_duplex <= 1'b1;
		// the crc model reads full_duplex at once, so let the new level settle first
		@(posedge clk);
		crc_run(2'b10, 1'b1, 1'b1, 16'hc3a5);
		wr16(16'hc0d4, 16'h0000);
		rd16(16'hc0d4, 16'h0000);
		wr16(16'hc0d2, 16'h3000);
		rd16(16'hc0d2, 16'h2400);
		$display("crc test done");
		finish_test();
	end
endmodule
